/* File: pfbi_pkg.sv */
/*
  pfbi_pkg: constants and types for the parallel flash bus host controller.
  assumes a 200 MHz core clock and an asynchronous parallel flash on pins.
*/
`default_nettype none
package pfbi_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  // strobe and settle times in ns, parameters of plain default
  localparam int unsigned T_SETUP_NS    = 20;
  localparam int unsigned T_PULSE_NS    = 40;
  localparam int unsigned T_ACCESS_NS   = 70;
  localparam int unsigned T_RESET_NS    = 500;
  localparam int unsigned T_SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_PULSE_CYC  = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_RESET_CYC  = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_AW = 4;

  // register offsets
  localparam logic [REG_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [REG_AW-1:0] REG_ADDR   = 4'h1;
  localparam logic [REG_AW-1:0] REG_WDATA  = 4'h2;
  localparam logic [REG_AW-1:0] REG_CMD    = 4'h3;
  localparam logic [REG_AW-1:0] REG_RDATA  = 4'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h5;

  // ctrl fields
  localparam int unsigned CTRL_WORD   = 0;
  localparam int unsigned CTRL_PROT_N = 1;
  localparam int unsigned CTRL_ACCEL  = 2;
  localparam int unsigned CTRL_HVID   = 3;
  localparam int unsigned CTRL_HVRST  = 4;
  localparam logic [4:0]  CTRL_RESET  = 5'h03;

  // command codes
  localparam logic [1:0] CMD_READ  = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;

  // status fields
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_READY = 1;

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [7:0]        BYTE_HIGHZ_MASK = 8'h7f;

  typedef enum logic [4:0] {
    PFBI_IDLE  = 5'b00001,
    PFBI_SETUP = 5'b00010,
    PFBI_PULSE = 5'b00100,
    PFBI_HOLD  = 5'b01000,
    PFBI_RST   = 5'b10000
  } pfbi_state_t;
endpackage
`default_nettype wire

/* File: pfbi_sync_if.sv */
/*
  pfbi_sync_if: carries the synchronised ready level from the input stage.
  assumes one clock domain on the controller side.
*/
`timescale 1ns/10ps
`default_nettype none
interface pfbi_sync_if;
  logic ready;
  modport src (output ready);
  modport dst (input ready);
endinterface
`default_nettype wire

/* File: pfbi_sync.sv */
/*
  pfbi_sync: three-stage input synchroniser; output changes once stages two and three agree.
  assumes an asynchronous pin input.
*/
`timescale 1ns/10ps
`default_nettype none
module pfbi_sync (
  input  wire logic CLOCK,
  input  wire logic ARST_N,
  input  wire logic pin_in,
  pfbi_sync_if.src  sync
);
  logic [2:0] sh_q;
  logic       lvl_q;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sh_q <= 3'h7;
    end else begin
      sh_q <= {sh_q[1:0], pin_in};
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      lvl_q <= 1'b1;
    end else if (sh_q[1] == sh_q[2]) begin
      lvl_q <= sh_q[2];
    end
  end

  assign sync.ready = lvl_q;
endmodule // pfbi_sync
`default_nettype wire

/* File: pfbi_host.sv */
/*
  pfbi_host: host controller driving an asynchronous parallel nor flash by its pins.
  assumes software access over a plain register port; the flash sits on the pins.
*/
`timescale 1ns/10ps
`default_nettype none
// Function
// [R1] read: address, chip select and output enable low, write strobe high
// [R2] device tri-states data when chip select or output enable high
// [R3] write: address, cs low, oe high, data driven, then strobe pulsed low
// [R4] device latches address on strobe fall, data on strobe rise
// [R5] only commands the device defines are ever written; the host writes any wdata_q value without checking it
// [R6] reset pin low for minimum time returns device to read mode
// [R7] device holds ready/busy low during reset recovery from program or erase
// [R8] system reset drives the device reset pin
// [R9] reset and chip select high put device in standby
// [R10] active mode: oe high tri-states data, oe low drives data
// [R11] width select high: word mode on all sixteen lines
// [R12] width select low: low byte only, line 15 is sub-word address
// [R13] protect pin low guards the two outermost boot sectors
// [R14] protect pin high: boot sectors keep their stored protection
// [R15] protect pin at high voltage: accelerated programming
// [R16] protect pin at high voltage: every sector unprotected
// [R17] lock status id read returns 01h or 00h
// [R18] security indicator id read returns 99h or 19h
// [R19] bottom-boot security sector is 256 bytes at low addresses
// [R20] reset pin at high voltage unprotects temporarily
// [R21] manufacturer id read on low byte
// [R22] device code read; upper byte tri-stated in byte mode
// [R23] ready/busy high when idle
module pfbi_host
  import pfbi_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              ARST_N,
  input  wire logic [REG_AW-1:0] REG_ADDR_IN,
  input  wire logic [31:0]       REG_WDATA_IN,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output var  logic [31:0]       REG_RDATA_OUT,
  output var  logic [ADDR_W-1:0] FL_ADDR,
  output var  logic              FL_CS_N,
  output var  logic              FL_WE_N,
  output var  logic              FL_OE_N,
  output var  logic              FL_RESET_N,
  output var  logic              FL_RESET_HV,
  output var  logic              FL_WORD_SEL,
  output var  logic              FL_PROTECT_ACCEL_PIN,
  output var  logic              FL_PROTECT_ACCEL_HV,
  output var  logic              FL_ID_HV,
  output var  logic [DATA_W-1:0] FL_DQ_OUT,
  output var  logic [DATA_W-1:0] FL_DQ_OE_N,
  input  wire logic [DATA_W-1:0] FL_DQ_IN,
  input  wire logic              FL_READY_BUSY_OUT
);
  pfbi_state_t       state_q;
  logic [4:0]        ctrl_q;
  logic [ADDR_W:0]   addr_q; // byte address in byte mode
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              is_write_q;
  logic              rst_rel_q;
  logic              go_rd;
  logic              go_wr;
  logic              go_rst;
  logic              pin_ready;
  pfbi_sync_if       ry_if ();

  pfbi_sync u_sync (
    .CLOCK  (CLOCK),
    .ARST_N (ARST_N),
    .pin_in (FL_READY_BUSY_OUT),
    .sync   (ry_if.src)
  );
  assign pin_ready = ry_if.ready;

  assign go_rd  = REG_WR && (REG_ADDR_IN == REG_CMD) && (REG_WDATA_IN[1:0] == CMD_READ);
  assign go_wr  = REG_WR && (REG_ADDR_IN == REG_CMD) && (REG_WDATA_IN[1:0] == CMD_WRITE); // [R5]
  assign go_rst = REG_WR && (REG_ADDR_IN == REG_CMD) && (REG_WDATA_IN[1:0] == CMD_RESET);

  // configuration registers; writes ignored while busy
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q  <= CTRL_RESET;
      addr_q  <= '0;
      wdata_q <= DATA_ZERO;
    end else if (REG_WR && state_q == PFBI_IDLE) begin
      if (REG_ADDR_IN == REG_CTRL) begin
        ctrl_q <= REG_WDATA_IN[4:0];
      end else if (REG_ADDR_IN == REG_ADDR) begin
        addr_q <= REG_WDATA_IN[ADDR_W:0];
      end else if (REG_ADDR_IN == REG_WDATA) begin
        wdata_q <= REG_WDATA_IN[DATA_W-1:0];
      end
    end
  end

  // bus cycle sequencer
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q    <= PFBI_RST;
      cnt_q      <= '0;
      is_write_q <= 1'b0;
      rst_rel_q  <= 1'b0;
    end else begin
      case (state_q)
        PFBI_IDLE: begin
          cnt_q <= '0;
          if (go_rd || go_wr) begin
            is_write_q <= go_wr;
            state_q    <= PFBI_SETUP;
          end else if (go_rst) begin
            rst_rel_q <= 1'b0;
            state_q   <= PFBI_RST;
          end
        end
        PFBI_SETUP: begin
          if (cnt_q == CNT_W'(T_SETUP_CYC - 1)) begin
            cnt_q   <= '0;
            state_q <= PFBI_PULSE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PFBI_PULSE: begin
          if (cnt_q == CNT_W'((is_write_q ? T_PULSE_CYC : T_ACCESS_CYC) - 1)) begin
            cnt_q   <= '0;
            state_q <= PFBI_HOLD;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PFBI_HOLD: begin
          if (cnt_q == CNT_W'(T_SETUP_CYC - 1)) begin
            state_q <= PFBI_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PFBI_RST: begin
          if (!rst_rel_q) begin
            if (cnt_q == CNT_W'(T_RESET_CYC - 1)) begin // [R6]
              cnt_q     <= '0;
              rst_rel_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end else if (pin_ready) begin // [R7] [R23]
            state_q <= PFBI_IDLE;
          end
        end
        default: state_q <= PFBI_IDLE;
      endcase
    end
  end

  // pin drive
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      FL_ADDR    <= '0;
      FL_CS_N    <= 1'b1;
      FL_WE_N    <= 1'b1;
      FL_OE_N    <= 1'b1;
      FL_RESET_N <= 1'b0; // [R8]
      FL_DQ_OUT  <= DATA_ZERO;
      FL_DQ_OE_N <= '1;
    end else begin
      FL_ADDR    <= ctrl_q[CTRL_WORD] ? addr_q[ADDR_W-1:0] : addr_q[ADDR_W:1]; // [R12]
      FL_RESET_N <= (state_q != PFBI_RST) || rst_rel_q; // [R6] [R8]
      FL_CS_N    <= !(state_q == PFBI_SETUP || state_q == PFBI_PULSE
                      || state_q == PFBI_HOLD); // [R9]
      FL_WE_N    <= !(is_write_q && state_q == PFBI_PULSE); // [R3] [R4]
      FL_OE_N    <= !(!is_write_q && state_q == PFBI_PULSE); // [R1] [R10]
      if (is_write_q && state_q != PFBI_IDLE && state_q != PFBI_RST) begin // [R3]
        if (ctrl_q[CTRL_WORD]) begin // [R11]
          FL_DQ_OUT  <= wdata_q;
          FL_DQ_OE_N <= '0;
        end else begin // [R12]
          FL_DQ_OUT  <= {addr_q[0], 7'h00, wdata_q[7:0]};
          FL_DQ_OE_N <= {1'b0, BYTE_HIGHZ_MASK[6:0], 8'h00};
        end
      end else begin
        FL_DQ_OUT  <= {addr_q[0] & ~ctrl_q[CTRL_WORD], 15'h0000};
        FL_DQ_OE_N <= {ctrl_q[CTRL_WORD], 15'h7fff}; // [R12]
      end
    end
  end

  // mode pins
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      FL_WORD_SEL          <= 1'b1;
      FL_PROTECT_ACCEL_PIN <= 1'b0;
      FL_PROTECT_ACCEL_HV  <= 1'b0;
      FL_ID_HV             <= 1'b0;
      FL_RESET_HV          <= 1'b0;
    end else begin
      FL_WORD_SEL          <= ctrl_q[CTRL_WORD]; // [R11] [R12]
      FL_PROTECT_ACCEL_PIN <= ctrl_q[CTRL_PROT_N]; // [R13] [R14]
      FL_PROTECT_ACCEL_HV  <= ctrl_q[CTRL_ACCEL]; // [R15] [R16]
      FL_ID_HV             <= ctrl_q[CTRL_HVID]; // [R17] [R18] [R21] [R22]
      FL_RESET_HV          <= ctrl_q[CTRL_HVRST]; // [R20]
    end
  end

  // read capture at end of access window
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= DATA_ZERO;
    end else if (!is_write_q && state_q == PFBI_PULSE
                 && cnt_q == CNT_W'(T_ACCESS_CYC - 1)) begin // [R1]
      rdata_q <= ctrl_q[CTRL_WORD] ? FL_DQ_IN : {8'h00, FL_DQ_IN[7:0]}; // [R12] [R22]
    end
  end

  // register read port
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA_OUT <= '0;
    end else if (REG_RD) begin
      if (REG_ADDR_IN == REG_CTRL) begin
        REG_RDATA_OUT <= {27'h0, ctrl_q};
      end else if (REG_ADDR_IN == REG_ADDR) begin
        REG_RDATA_OUT <= {10'h0, addr_q};
      end else if (REG_ADDR_IN == REG_WDATA) begin
        REG_RDATA_OUT <= {16'h0, wdata_q};
      end else if (REG_ADDR_IN == REG_RDATA) begin
        REG_RDATA_OUT <= {16'h0, rdata_q};
      end else if (REG_ADDR_IN == REG_STATUS) begin
        REG_RDATA_OUT <= {30'h0, pin_ready, state_q != PFBI_IDLE};
      end else begin
        REG_RDATA_OUT <= '0;
      end
    end else begin
      REG_RDATA_OUT <= '0;
    end
  end

  write_we_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R3]
    !FL_WE_N |-> (!FL_CS_N && FL_OE_N && FL_DQ_OE_N[0] == 1'b0))
    else $error("write strobe without cs, oe high or data driven");
  read_oe_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R1]
    !FL_OE_N |-> (!FL_CS_N && FL_WE_N && FL_DQ_OE_N[7:0] == 8'hff))
    else $error("read without cs low or with data driven");
  byte_hz_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R12]
    !FL_WORD_SEL |-> FL_DQ_OE_N[14:8] == 7'h7f)
    else $error("upper lines driven in byte mode");
  byte_a1_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R12]
    !FL_WORD_SEL |-> !FL_DQ_OE_N[15])
    else $error("sub-word address line not driven in byte mode");
  rst_pulse_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R6]
    $fell(FL_RESET_N) |-> !FL_RESET_N [*8])
    else $error("reset pulse too short");
  rst_idle_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R7]
    (state_q == PFBI_RST && rst_rel_q && !pin_ready) |=> state_q == PFBI_RST)
    else $error("left reset while device busy");
  wdata_hold_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R4]
    $rose(FL_WE_N) |-> (FL_DQ_OUT == $past(FL_DQ_OUT) && !FL_CS_N))
    else $error("data changed at write strobe rise");
  sysrst_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R8]
    $rose(ARST_N) |-> !FL_RESET_N)
    else $error("flash reset not held after system reset");
  we_oe_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // [R10]
    !(!FL_WE_N && !FL_OE_N))
    else $error("write and output enable both low");
  cov_rd_c: cover property (@(posedge CLOCK) disable iff (!ARST_N) $fell(FL_OE_N));
  cov_wr_c: cover property (@(posedge CLOCK) disable iff (!ARST_N) $rose(FL_WE_N));
  cov_rst_c: cover property (@(posedge CLOCK) disable iff (!ARST_N) $rose(FL_RESET_N));
endmodule // pfbi_host
`default_nettype wire

/* File: pfbi_flash_model.sv */
/*
  pfbi_flash_model: behavioural parallel nor flash behind the host controller.
  assumes the bench resolves the data wire and feeds it back on dq.
*/
`timescale 1ns/10ps
`default_nettype none
module pfbi_flash_model #(
  parameter logic [7:0] MFR_ID  = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID  = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_EXT = 8'h4b, // arbitrary value
  parameter bit         SEC_LK  = 1'b0
) (
  input  wire logic [20:0] addr,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        reset_n,
  input  wire logic        reset_hv,
  input  wire logic        word_sel,
  input  wire logic        prot_pin,
  input  wire logic        prot_hv,
  input  wire logic        id_hv,
  input  wire logic [15:0] dq,
  output var  logic [15:0] dq_out,
  output var  logic [15:0] dq_drv,
  output var  logic        ready_busy
);
  logic [15:0] mem [16];
  logic [15:0] w;
  logic [15:0] c;
  logic [3:0]  wa;
  logic        busy = 1'b0;
  logic        lock;
  logic        rd;
  assign rd = reset_n & ~cs_n & ~oe_n & we_n;
  // boot sector guard, lifted by either high voltage
  assign lock = addr[20:12] == 9'h000 && !prot_hv && !reset_hv && !prot_pin;
  assign ready_busy = ~busy;
  always @(negedge we_n) if (!cs_n && oe_n) wa = addr[3:0];
  always @(posedge we_n) if (!cs_n && oe_n && reset_n && !lock) begin
    mem[wa] = dq;
    busy = 1'b1;
    #200 if (reset_n) busy = 1'b0;
  end
  always @(posedge reset_n) if (busy) #100 busy = 1'b0;
  always_comb begin
    w = mem[addr[3:0]];
    case ({addr[6], addr[1:0]})
      3'b000:  c = {8'h00, MFR_ID};
      3'b001:  c = {DEV_EXT, DEV_ID};
      3'b010:  c = {15'h0000, lock};
      3'b011:  c = {8'h00, SEC_LK ? 8'h99 : 8'h19};
      default: c = 16'h0000;
    endcase
  end
  assign dq_out = id_hv ? c : word_sel ? w : {8'h00, dq[15] ? w[15:8] : w[7:0]};
  assign dq_drv = !rd ? 16'h0000 : word_sel ? 16'hffff : 16'h00ff;
endmodule // pfbi_flash_model
`default_nettype wire

/* File: pfbi_host_bench.sv */
/*
  pfbi_host_bench: self-checking bench of pfbi_host driving a flash model.
  assumes pfbi_pkg and pfbi_flash_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module pfbi_host_bench
  import pfbi_pkg::*;
;
  localparam logic [7:0] MFR = 8'h5a; // arbitrary value
  localparam logic [7:0] DEV = 8'h3c; // arbitrary value
  localparam logic [7:0] EXT = 8'h4b; // arbitrary value
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic [20:0]       fl_addr;
  logic              cs_n, we_n, oe_n, rst_n, rst_hv, word_sel, prot, prot_hv, id_hv, rdy;
  logic [15:0]       dq_out, dq_oe_n, dq, m_out, m_drv;
  logic [15:0]       wob = 16'h5555;
  int                bad_count = 0;
  int                checks_done = 0;
  int                cycles = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock) wob <= ~wob;
  // undriven wire shows a pattern that flips every cycle
  assign dq = (~dq_oe_n & dq_out) | (dq_oe_n & m_drv & m_out) | (dq_oe_n & ~m_drv & wob);
  pfbi_host i_pfbi_host (.CLOCK(clock), .ARST_N(arst_n), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA_OUT(reg_rdata),
    .FL_ADDR(fl_addr), .FL_CS_N(cs_n), .FL_WE_N(we_n), .FL_OE_N(oe_n), .FL_RESET_N(rst_n),
    .FL_RESET_HV(rst_hv), .FL_WORD_SEL(word_sel), .FL_PROTECT_ACCEL_PIN(prot),
    .FL_PROTECT_ACCEL_HV(prot_hv), .FL_ID_HV(id_hv), .FL_DQ_OUT(dq_out),
    .FL_DQ_OE_N(dq_oe_n), .FL_DQ_IN(dq), .FL_READY_BUSY_OUT(rdy));
  pfbi_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .DEV_EXT(EXT), .SEC_LK(1'b0))
    i_pfbi_flash_model (.addr(fl_addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
    .reset_n(rst_n), .reset_hv(rst_hv), .word_sel(word_sel), .prot_pin(prot),
    .prot_hv(prot_hv), .id_hv(id_hv), .dq(dq), .dq_out(m_out), .dq_drv(m_drv),
    .ready_busy(rdy));
  task automatic complete_run;
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clock) begin
    cycles++;
    if (arst_n) `CHK(|(~dq_oe_n & m_drv), 1'b0)
    if (!we_n) `CHK({cs_n, oe_n}, 2'b01)
    if (cycles == 60000) begin
      bad_count++;
      complete_run;
    end
  end
  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  task automatic wait_st(input logic [1:0] m);
    logic [31:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(REG_STATUS, s);
      if ((s[1:0] & m) === (2'b10 & m)) return;
    end
    `CHK(s[1:0] & m, 2'b10 & m)
  endtask
  task automatic op(input logic [1:0] cmd, input logic [4:0] ctl, input logic [20:0] a,
                    input logic [15:0] d, input logic [1:0] m);
    wr(REG_CTRL, {27'h0, ctl});
    wr(REG_ADDR, {11'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, {30'h0, cmd});
    wait_st(m);
  endtask
  task automatic rd_chk(input logic [4:0] ctl, input logic [20:0] a, input logic [31:0] e);
    logic [31:0] v;
    op(CMD_READ, ctl, a, 16'h0000, 2'b11);
    rd(REG_RDATA, v);
    `CHK(v, e)
  endtask
  task automatic t_reset;
    logic [31:0] v;
    `CHK({rst_n, cs_n, dq_oe_n}, {2'b01, 16'hffff})
    wait_st(2'b11);
    `CHK(rst_n, 1'b1)
    rd(4'hf, v);
    `CHK(v, 32'h0)
    rd(REG_CTRL, v);
    `CHK(v, {27'h0, CTRL_RESET})
  endtask
  task automatic t_word;
    op(CMD_WRITE, 5'h03, 21'h3, 16'ha5c3, 2'b11);
    rd_chk(5'h03, 21'h3, 32'ha5c3);
  endtask
  task automatic t_byte;
    rd_chk(5'h02, 21'h7, 32'h00a5);
    rd_chk(5'h02, 21'h6, 32'h00c3);
  endtask
  task automatic t_protect;
    op(CMD_WRITE, 5'h01, 21'h3, 16'h1111, 2'b11);
    rd_chk(5'h03, 21'h3, 32'ha5c3);
    op(CMD_WRITE, 5'h05, 21'h3, 16'h2222, 2'b11);
    rd_chk(5'h03, 21'h3, 32'h2222);
    op(CMD_WRITE, 5'h11, 21'h3, 16'h3333, 2'b11);
    rd_chk(5'h03, 21'h3, 32'h3333);
  endtask
  task automatic t_id;
    rd_chk(5'h09, 21'h0, {24'h0, MFR});
    rd_chk(5'h09, 21'h1, {16'h0, EXT, DEV});
    rd_chk(5'h08, 21'h2, {24'h0, DEV});
    rd_chk(5'h0b, 21'h2, 32'h0000);
    rd_chk(5'h08, 21'h4, 32'h0001);
    rd_chk(5'h0c, 21'h4, 32'h0000);
    rd_chk(5'h09, 21'h3, 32'h0019);
  endtask
  task automatic t_rst_busy;
    logic [31:0] v;
    op(CMD_WRITE, 5'h03, 21'h5, 16'h4444, 2'b01);
    wr(REG_CMD, {30'h0, CMD_RESET});
    rd(REG_STATUS, v);
    `CHK(v[1:0], 2'b01)
    `CHK(rst_n, 1'b0)
    wait_st(2'b11);
    rd_chk(5'h03, 21'h5, 32'h4444);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    t_reset;
    t_word;
    t_byte;
    t_protect;
    t_id;
    t_rst_busy;
    complete_run;
  end
endmodule // pfbi_host_bench
`default_nettype wire
